// >>> rtl/core_exec.sv
// Instruction execution core of an 8-bit accumulator machine.
// Assumes program and data memories answer combinationally within a phase.
`timescale 1ns/1ps
`default_nettype none
module core_exec
	import core_exec_pkg::*;
#(
	parameter int STACK_LEVELS = STACK_DEPTH
) (
	input wire logic CORE_CLK_I,              // System clock, 50 MHz
	input wire logic RESET_I,                 // Synchronous reset, high
	input wire logic [15:0] PMEM_DATA_I,      // Program memory word
	input wire logic [7:0] DMEM_RDATA_I,      // Sector 0 data memory byte
	input wire logic [7:0] TBL_PAGE_I,        // Table page for specific-page reads
	input wire logic WDT_TICK_I,              // Watchdog count enable
	output logic [PADDR_W-1:0] PMEM_ADDR_O,   // Program memory address
	output logic DMEM_WE_O,                   // Data memory write strobe
	output logic [DADDR_W-1:0] DMEM_ADDR_O,   // Data memory address
	output logic [7:0] DMEM_WDATA_O,          // Data memory write data
	output logic [7:0] ACC_O,                 // Accumulator
	output logic [7:0] FLAGS_O,               // Status flags
	output logic [7:0] TABLE_HIGH_BYTE_O,                // Table high byte
	output logic [7:0] TABLE_POINTER_O,                // Table pointer
	output logic GIE_O,                       // Global interrupt enable
	output logic POWERDOWN_O,                 // Power-down mode
	output logic [15:0] WDT_O                 // Watchdog count
);
	// The stack is indexed by three pointer bits, so only a depth of
	// eight is served; anything else would wrap onto live entries.
	if (STACK_LEVELS != 8) begin : g_bad_depth
		$error("STACK_LEVELS must be 8");
	end

	typedef enum logic [1:0] {ST_FETCH, ST_EXEC, ST_EXTRA} state_t;

	state_t state_reg;
	logic [1:0] phase_reg;
	logic [PADDR_W-1:0] pc_reg;
	logic [7:0] acc_reg;
	logic [7:0] flags_reg;
	logic [7:0] table_high_byte_reg;
	logic [7:0] table_pointer_reg;
	logic gie_reg;
	logic pdn_reg;
	logic [15:0] wdt_reg;
	logic [PADDR_W-1:0] pmem_addr_reg;
	dmem_req_t dreq_reg;
	instr_t ir_reg;
	logic [PADDR_W-1:0] stack_mem [STACK_LEVELS];
	logic [3:0] sp_reg;
	instr_t ir_next;

	logic icyc_end;
	logic [7:0] alu_res;
	logic [7:0] alu_flags;
	logic [7:0] b_op;
	logic skip;
	logic writes_pcl;
	logic two_cycle;

	// Four system clocks per instruction cycle
	assign icyc_end = (phase_reg == PHASE_LAST);

	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I || pdn_reg)
			phase_reg <= 2'h0;
		else
			phase_reg <= phase_reg + 2'h1;
	end

	// Operand select: immediate data or sector 0 memory byte
	assign b_op = ir_reg.use_imm ? ir_reg.opnd : DMEM_RDATA_I;

	core_alu u_alu (
		.op_i(ir_reg.op),
		.a_i(acc_reg),
		.b_i(b_op),
		.bit_i(ir_reg.opnd[2:0]),
		.flags_i(flags_reg),
		.res_o(alu_res),
		.flags_o(alu_flags)
	);

	// Skip decision from the value under test
	always_comb begin
		unique case (ir_reg.op)
			OP_SZ, OP_SZA: skip = (DMEM_RDATA_I == 8'h00);
			OP_SNZ: skip = (DMEM_RDATA_I != 8'h00);
			OP_SZB: skip = ~DMEM_RDATA_I[ir_reg.opnd[2:0]];
			OP_SNZB: skip = DMEM_RDATA_I[ir_reg.opnd[2:0]];
			OP_SIZ, OP_SDZ: skip = (alu_res == 8'h00);
			default: skip = 1'b0;
		endcase
	end

	// Memory destination equal to the program counter low byte
	always_comb begin
		unique case (ir_reg.op)
			OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR, OP_CPL,
			OP_INC, OP_DEC, OP_RR, OP_RL, OP_RRC, OP_RLC, OP_SIZ, OP_SDZ,
			OP_CLRB, OP_SETB, OP_CLR, OP_SET, OP_SWAP, OP_DAA, OP_MOV_AM:
				writes_pcl = (ir_reg.to_mem || ir_reg.op == OP_DAA || ir_reg.op == OP_MOV_AM)
					&& !ir_reg.use_imm && (ir_reg.opnd == PCL_ADDR);
			default: writes_pcl = 1'b0;
		endcase
	end

	// Instructions that spend a second instruction cycle
	always_comb begin
		unique case (ir_reg.op)
			OP_JMP, OP_CALL, OP_RET, OP_RETX, OP_RETURN_FROM_IRQ, OP_TABLE_READ_PAGE, OP_TABLE_READ_LAST_PAGE:
				two_cycle = 1'b1;
			default: two_cycle = skip || writes_pcl;
		endcase
	end

	// Word layout: op in the top six bits, then the destination bit and
	// the immediate bit, then the 8-bit operand.
	// Table reads always land in data memory, so their pre-increment
	// choice shares the destination bit; this keeps the word at 16 bits.
	// Op codes past the last enum entry decode as no operation,
	// since every case below falls to its default for them.
	always_comb begin
		ir_next = '0;
		ir_next.op = op_t'(PMEM_DATA_I[15:10]);
		ir_next.to_mem = PMEM_DATA_I[9];
		ir_next.use_imm = PMEM_DATA_I[8];
		ir_next.preinc = PMEM_DATA_I[9];
		ir_next.opnd = PMEM_DATA_I[7:0];
	end

	// Sequencer: fetch, execute, optional extra cycle
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			state_reg <= ST_FETCH;
			ir_reg <= '0;
		end else if (icyc_end) begin
			unique case (state_reg)
				ST_FETCH: begin
					ir_reg <= ir_next;
					state_reg <= ST_EXEC;
				end
				ST_EXEC: state_reg <= two_cycle ? ST_EXTRA : ST_FETCH;
				ST_EXTRA: state_reg <= ST_FETCH;
			endcase
		end
	end

	// Program counter and return stack
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			pc_reg <= PC_RESET;
			sp_reg <= 4'h0;
		end else if (icyc_end) begin
			if (state_reg == ST_FETCH)
				pc_reg <= pc_reg + 13'h0001;
			else if (state_reg == ST_EXEC) begin
				unique case (ir_reg.op)
					OP_JMP: pc_reg <= {5'h00, ir_reg.opnd};
					OP_CALL: begin
						stack_mem[sp_reg[2:0]] <= pc_reg;
						sp_reg <= sp_reg + 4'h1;
						pc_reg <= {5'h00, ir_reg.opnd};
					end
					OP_RET, OP_RETX, OP_RETURN_FROM_IRQ: begin
						pc_reg <= stack_mem[sp_reg[2:0] - 3'h1];
						sp_reg <= sp_reg - 4'h1;
					end
					default: begin
						if (skip)
							pc_reg <= pc_reg + 13'h0001;
						else if (writes_pcl)
							pc_reg <= {pc_reg[PADDR_W-1:8], alu_res};
					end
				endcase
			end
		end
	end

	// Accumulator and flags
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			acc_reg <= ACC_RESET;
			flags_reg <= 8'h00;
		end else if (icyc_end && state_reg == ST_EXEC) begin
			unique case (ir_reg.op)
				OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR, OP_CPL,
				OP_INC, OP_DEC, OP_RRC, OP_RLC, OP_RR, OP_RL, OP_SWAP: begin
					flags_reg <= alu_flags;
					if (!ir_reg.to_mem)
						acc_reg <= alu_res;
				end
				OP_DAA: flags_reg <= alu_flags;
				OP_SIZ, OP_SDZ: if (!ir_reg.to_mem) acc_reg <= alu_res;
				OP_MOV_MA, OP_SZA: acc_reg <= DMEM_RDATA_I;
				OP_MOV_XA, OP_RETX: acc_reg <= ir_reg.opnd;
				OP_CLRWDT: begin
					flags_reg[FLAG_TO] <= 1'b0;
					flags_reg[FLAG_PDF] <= 1'b0;
				end
				OP_HALT: begin
					flags_reg[FLAG_TO] <= 1'b0;
					flags_reg[FLAG_PDF] <= 1'b1;
				end
				default: acc_reg <= acc_reg;
			endcase
		end
		// Expiry is a hardware set; placed last so that it wins over any
		// flag write or watchdog clear landing on the same edge
		if (!RESET_I && wdt_reg == 16'hffff && WDT_TICK_I)
			flags_reg[FLAG_TO] <= 1'b1;
	end

	// Interrupt enable and power-down
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			gie_reg <= 1'b0;
			pdn_reg <= 1'b0;
		end else if (icyc_end && state_reg == ST_EXEC) begin
			if (ir_reg.op == OP_RETURN_FROM_IRQ)
				gie_reg <= 1'b1;
			if (ir_reg.op == OP_HALT)
				pdn_reg <= 1'b1;
		end else if (pdn_reg && wdt_reg == 16'hffff && WDT_TICK_I)
			pdn_reg <= 1'b0; // Watchdog expiry is the only wake source here
	end

	// Watchdog count; clear wins over the tick
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I)
			wdt_reg <= WDT_RESET;
		else if (icyc_end && state_reg == ST_EXEC && (ir_reg.op == OP_CLRWDT || ir_reg.op == OP_HALT))
			wdt_reg <= WDT_RESET;
		else if (WDT_TICK_I)
			wdt_reg <= wdt_reg + 16'h0001;
	end

	// Table pointer, table high byte, program memory address
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			table_pointer_reg <= TABLE_POINTER_RESET;
			table_high_byte_reg <= 8'h00;
			pmem_addr_reg <= PC_RESET;
		end else if (phase_reg == 2'h2) begin
			if (state_reg == ST_EXEC && (ir_reg.op == OP_TABLE_READ_PAGE || ir_reg.op == OP_TABLE_READ_LAST_PAGE)) begin
				// Last page is all ones in the upper address bits
				pmem_addr_reg <= {(ir_reg.op == OP_TABLE_READ_LAST_PAGE) ? 5'h1f : TBL_PAGE_I[4:0],
					ir_reg.preinc ? table_pointer_reg + 8'h01 : table_pointer_reg};
				if (ir_reg.preinc)
					table_pointer_reg <= table_pointer_reg + 8'h01;
			end else
				pmem_addr_reg <= pc_reg;
			// The table word is only on the bus until the address moves back
			// to the program counter on this very edge, so take it now
			if (state_reg == ST_EXTRA && (ir_reg.op == OP_TABLE_READ_PAGE || ir_reg.op == OP_TABLE_READ_LAST_PAGE))
				table_high_byte_reg <= PMEM_DATA_I[15:8];
		end
	end

	// Data memory port, sector 0 only
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I)
			dreq_reg <= '0;
		else begin
			dreq_reg.addr <= ir_reg.opnd;
			dreq_reg.we <= 1'b0;
			if (phase_reg == 2'h2 && state_reg == ST_EXEC) begin
				unique case (ir_reg.op)
					OP_DAA, OP_MOV_AM, OP_CLRB, OP_SETB, OP_CLR, OP_SET: begin
						dreq_reg.we <= 1'b1;
						dreq_reg.wdata <= alu_res;
					end
					OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR, OP_CPL, OP_INC,
					OP_DEC, OP_RR, OP_RL, OP_RRC, OP_RLC, OP_SWAP, OP_SIZ, OP_SDZ: begin
						dreq_reg.we <= ir_reg.to_mem && !ir_reg.use_imm;
						dreq_reg.wdata <= alu_res;
					end
					default: dreq_reg.we <= 1'b0;
				endcase
			end else if (phase_reg == 2'h2 && state_reg == ST_EXTRA
				&& (ir_reg.op == OP_TABLE_READ_PAGE || ir_reg.op == OP_TABLE_READ_LAST_PAGE)) begin
				dreq_reg.we <= 1'b1;
				dreq_reg.wdata <= PMEM_DATA_I[7:0];
			end
		end
	end

	// Outputs straight from flip-flops
	assign PMEM_ADDR_O = pmem_addr_reg;
	assign DMEM_WE_O = dreq_reg.we;
	assign DMEM_ADDR_O = dreq_reg.addr;
	assign DMEM_WDATA_O = dreq_reg.wdata;
	assign ACC_O = acc_reg;
	assign FLAGS_O = flags_reg;
	assign TABLE_HIGH_BYTE_O = table_high_byte_reg;
	assign TABLE_POINTER_O = table_pointer_reg;
	assign GIE_O = gie_reg;
	assign POWERDOWN_O = pdn_reg;
	assign WDT_O = wdt_reg;
endmodule
`default_nettype wire

// >>> rtl/core_exec_pkg.sv
// Shared constants and types for the instruction execution core.
// Assumes a single 50 MHz clock and a synchronous active-high reset.
package core_exec_pkg;
	// Instruction cycle length in system clocks
	localparam int SYS_PER_ICYCLE = 4;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	// Address widths and stack depth
	localparam int PADDR_W = 13;
	localparam int DADDR_W = 8;
	localparam int STACK_DEPTH = 8;
	// Data memory address of the program counter low byte
	localparam logic [7:0] PCL_ADDR = 8'h06;
	// Reset values
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [7:0] TABLE_POINTER_RESET = 8'h00;
	localparam logic [15:0] WDT_RESET = 16'h0000;
	// Field positions of the flag vector
	localparam int FLAG_Z = 0;
	localparam int FLAG_C = 1;
	localparam int FLAG_HC = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_SC = 4;
	localparam int FLAG_CZ = 5;
	localparam int FLAG_TO = 6;
	localparam int FLAG_PDF = 7;

	// Operation classes, encoding is implementation defined
	typedef enum logic [5:0] {
		OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_DAA,
		OP_AND, OP_OR, OP_XOR, OP_CPL, OP_INC, OP_DEC,
		OP_RR, OP_RL, OP_RRC, OP_RLC, OP_MOV_MA, OP_MOV_AM, OP_MOV_XA,
		OP_CLRB, OP_SETB, OP_JMP, OP_CALL, OP_RET, OP_RETX, OP_RETURN_FROM_IRQ,
		OP_SZ, OP_SNZ, OP_SZA, OP_SZB, OP_SNZB, OP_SIZ, OP_SDZ,
		OP_TABLE_READ_PAGE, OP_TABLE_READ_LAST_PAGE, OP_CLR, OP_SET, OP_SWAP, OP_CLRWDT, OP_HALT
	} op_t;

	// Decoded instruction word, 17 bits wide
	typedef struct packed {
		op_t op;          // Operation
		logic to_mem;     // Result to memory when set, else to accumulator
		logic use_imm;    // Operand is immediate data
		logic preinc;     // Table read pre-increments pointer
		logic [7:0] opnd; // Address, immediate data, or bit number
	} instr_t;

	// Data memory access request
	typedef struct packed {
		logic we;
		logic [DADDR_W-1:0] addr;
		logic [7:0] wdata;
	} dmem_req_t;
endpackage

// >>> rtl/core_alu.sv
// Combinational arithmetic and logic unit of the execution core.
// Assumes operands are stable for the whole instruction cycle.
`timescale 1ns/1ps
`default_nettype none
module core_alu
	import core_exec_pkg::*;
(
	input wire op_t op_i,          // Operation
	input wire logic [7:0] a_i,    // Accumulator
	input wire logic [7:0] b_i,    // Memory byte or immediate
	input wire logic [2:0] bit_i,  // Bit number
	input wire logic [7:0] flags_i, // Current flags
	output logic [7:0] res_o,      // Result byte
	output logic [7:0] flags_o     // Next flags
);
	logic [8:0] sum;
	logic [4:0] half;
	logic cin;

	// Add and subtract share one adder; subtraction adds the inverse
	always_comb begin
		res_o = b_i;
		flags_o = flags_i;
		cin = 1'b0;
		sum = 9'h000;
		half = 5'h00;
		unique case (op_i)
			OP_ADD, OP_ADC: begin
				cin = (op_i == OP_ADC) ? flags_i[FLAG_C] : 1'b0;
				sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin};
				half = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin};
				res_o = sum[7:0];
				flags_o[FLAG_C] = sum[8];
				flags_o[FLAG_HC] = half[4];
				flags_o[FLAG_OV] = (a_i[7] == b_i[7]) && (sum[7] != a_i[7]);
				flags_o[FLAG_SC] = sum[7];
				flags_o[FLAG_Z] = (sum[7:0] == 8'h00);
			end
			OP_SUB, OP_SBC: begin
				// Carry set means no borrow
				cin = (op_i == OP_SBC) ? flags_i[FLAG_C] : 1'b1;
				sum = {1'b0, a_i} + {1'b0, ~b_i} + {8'h00, cin};
				half = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + {4'h0, cin};
				res_o = sum[7:0];
				flags_o[FLAG_C] = sum[8];
				flags_o[FLAG_HC] = half[4];
				flags_o[FLAG_OV] = (a_i[7] != b_i[7]) && (sum[7] != a_i[7]);
				flags_o[FLAG_SC] = sum[7];
				flags_o[FLAG_Z] = (sum[7:0] == 8'h00);
				// Chained zero: with SBC, clear when the previous result left the Z flag clear
				flags_o[FLAG_CZ] = (sum[7:0] == 8'h00) && ((op_i == OP_SUB) || flags_i[FLAG_Z]);
			end
			OP_DAA: begin
				sum = {1'b0, a_i};
				if (a_i[3:0] > 4'h9 || flags_i[FLAG_HC])
					sum = sum + 9'h006;
				if (sum[7:4] > 4'h9 || sum[8] || flags_i[FLAG_C])
					sum = sum + 9'h060;
				res_o = sum[7:0];
				flags_o[FLAG_C] = sum[8] | flags_i[FLAG_C];
			end
			OP_AND, OP_OR, OP_XOR: begin
				res_o = (op_i == OP_AND) ? (a_i & b_i) : (op_i == OP_OR) ? (a_i | b_i) : (a_i ^ b_i);
				flags_o[FLAG_Z] = (res_o == 8'h00);
			end
			OP_CPL: begin
				res_o = ~b_i;
				flags_o[FLAG_Z] = (res_o == 8'h00);
			end
			OP_INC, OP_SIZ: begin
				res_o = b_i + 8'h01;
				if (op_i == OP_INC)
					flags_o[FLAG_Z] = (res_o == 8'h00);
			end
			OP_DEC, OP_SDZ: begin
				res_o = b_i - 8'h01;
				if (op_i == OP_DEC)
					flags_o[FLAG_Z] = (res_o == 8'h00);
			end
			OP_RR: res_o = {b_i[0], b_i[7:1]};
			OP_RL: res_o = {b_i[6:0], b_i[7]};
			OP_RRC: begin
				res_o = {flags_i[FLAG_C], b_i[7:1]};
				flags_o[FLAG_C] = b_i[0];
			end
			OP_RLC: begin
				res_o = {b_i[6:0], flags_i[FLAG_C]};
				flags_o[FLAG_C] = b_i[7];
			end
			OP_MOV_AM: res_o = a_i;
			OP_CLRB: res_o = b_i & ~(8'h01 << bit_i);
			OP_SETB: res_o = b_i | (8'h01 << bit_i);
			OP_CLR: res_o = 8'h00;
			OP_SET: res_o = 8'hff;
			OP_SWAP: res_o = {b_i[3:0], b_i[7:4]};
			default: res_o = b_i;
		endcase
	end
endmodule
`default_nettype wire

// >>> dv/core_mem_model.sv
// Program memory and sector-0 data memory standing beside the core.
// Assumes the core wants both read ports answered within the same phase.
`timescale 1ns/1ps
`default_nettype none
module core_mem_model
	import core_exec_pkg::*;
(
	input wire logic clk_i,                  // System clock
	input wire logic [PADDR_W-1:0] paddr_i,  // Fetch address
	output logic [15:0] pdata_o,             // Program word
	input wire logic we_i,                   // Data write strobe
	input wire logic [DADDR_W-1:0] daddr_i,  // Data address
	input wire logic [7:0] wdata_i,          // Data to write
	output logic [7:0] rdata_o               // Data read back
);
	logic [15:0] pmem [0:(1<<PADDR_W)-1] = '{default: 16'h0000};
	logic [7:0] dmem [0:255];
	// Both reads are combinational, as the core has no wait state
	assign pdata_o = pmem[paddr_i];
	assign rdata_o = dmem[daddr_i];
	// Only sector 0 exists here, so every 8-bit address is a real byte
	always @(posedge clk_i) begin
		if (we_i) begin
			dmem[daddr_i] <= wdata_i;
		end
	end
endmodule
`default_nettype wire

// >>> dv/core_exec_asserts.sv
// Cadence checks on the core ports: reset state, write and fetch slots.
// Assumes it is bound to every core_exec instance.
`timescale 1ns/1ps
`default_nettype none
module core_exec_asserts
	import core_exec_pkg::*;
#(
	parameter int STACK_LEVELS = STACK_DEPTH
) (
	input wire logic CORE_CLK_I,              // Clock
	input wire logic RESET_I,                 // Reset
	input wire logic [PADDR_W-1:0] PMEM_ADDR_O, // Fetch address
	input wire logic DMEM_WE_O,               // Write strobe
	input wire logic [7:0] ACC_O,             // Accumulator
	input wire logic [7:0] FLAGS_O,           // Flags
	input wire logic GIE_O                    // Interrupt enable
);
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (RESET_I);
	logic [1:0] ph_reg;
	logic [1:0] wph_reg;
	logic [1:0] pph_reg;
	logic wseen_reg;
	logic pseen_reg;
	// Remember the clock slot of the first write and fetch move
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			ph_reg <= 2'h0;
			wph_reg <= 2'h0;
			pph_reg <= 2'h0;
			wseen_reg <= 1'b0;
			pseen_reg <= 1'b0;
		end else begin
			ph_reg <= ph_reg + 2'h1;
			if (DMEM_WE_O && !wseen_reg) begin
				wseen_reg <= 1'b1;
				wph_reg <= ph_reg;
			end
			if ($changed(PMEM_ADDR_O) && !pseen_reg) begin
				pseen_reg <= 1'b1;
				pph_reg <= ph_reg;
			end
		end
	end
	property p_reset_clear;
		$fell(RESET_I) |-> PMEM_ADDR_O == 13'h0000 && ACC_O == 8'h00 && FLAGS_O == 8'h00 && !GIE_O && !DMEM_WE_O;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
	property p_we_spacing;
		DMEM_WE_O |=> !DMEM_WE_O [*3];
	endproperty
	a_we_spacing: assert property (p_we_spacing) else $error("writes closer than one cycle");
	property p_we_phase;
		DMEM_WE_O && wseen_reg |-> ph_reg == wph_reg;
	endproperty
	a_we_phase: assert property (p_we_phase) else $error("write in wrong clock slot");
	property p_pc_spacing;
		$changed(PMEM_ADDR_O) |=> $stable(PMEM_ADDR_O) [*3];
	endproperty
	a_pc_spacing: assert property (p_pc_spacing) else $error("fetch address moved too soon");
	property p_pc_phase;
		$changed(PMEM_ADDR_O) && pseen_reg |-> ph_reg == pph_reg;
	endproperty
	a_pc_phase: assert property (p_pc_phase) else $error("fetch address moved off slot");
	property p_acc_spacing;
		$changed(ACC_O) |=> $stable(ACC_O) [*3];
	endproperty
	a_acc_spacing: assert property (p_acc_spacing) else $error("accumulator moved too soon");
	property p_flags_spacing;
		$changed(FLAGS_O) |=> $stable(FLAGS_O) [*3];
	endproperty
	a_flags_spacing: assert property (p_flags_spacing) else $error("flags moved too soon");
	property p_gie_hold;
		GIE_O |=> GIE_O;
	endproperty
	a_gie_hold: assert property (p_gie_hold) else $error("interrupt enable dropped");
	c_write: cover property (DMEM_WE_O);
	c_gie: cover property ($rose(GIE_O));
	c_jump: cover property ($changed(PMEM_ADDR_O) && PMEM_ADDR_O != $past(PMEM_ADDR_O) + 13'h0001);
endmodule
bind core_exec core_exec_asserts #(.STACK_LEVELS(STACK_LEVELS)) chk (.CORE_CLK_I(CORE_CLK_I),
	.RESET_I(RESET_I), .PMEM_ADDR_O(PMEM_ADDR_O), .DMEM_WE_O(DMEM_WE_O), .ACC_O(ACC_O),
	.FLAGS_O(FLAGS_O), .GIE_O(GIE_O));
`default_nettype wire

// >>> dv/mcu_core_instruction_execution_tb.sv
// Steps single instructions through the core and checks each against a model.
// Assumes the memory model answers at once and every word is fetched afresh.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
$display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module mcu_core_instruction_execution_tb
	import core_exec_pkg::*;
;
	logic CORE_CLK_I = 1'b0;
	logic RESET_I = 1'b1;
	logic WDT_TICK_I = 1'b0;
	logic [7:0] TBL_PAGE_I = 8'h00;
	logic [15:0] PMEM_DATA_I, WDT_O;
	logic [7:0] DMEM_RDATA_I, DMEM_ADDR_O, DMEM_WDATA_O, ACC_O, FLAGS_O, TABLE_HIGH_BYTE_O, TABLE_POINTER_O;
	logic [12:0] PMEM_ADDR_O;
	logic DMEM_WE_O, GIE_O, POWERDOWN_O;
	int seed = 32'h694e;
	int fail_count = 0;
	int check_count = 0;
	int opl[26] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 26, 27, 28, 31, 34, 35, 36, 37};
	logic [7:0] table_pointer = 8'h00;
	logic [7:0] table_high_byte = 8'h00;
	logic [7:0] acc = 8'h00;
	logic [7:0] flg = 8'h00;
	logic [7:0] em [0:255];
	logic [7:0] v;
	logic [12:0] pc = 13'h0000;
	logic [12:0] stk [$];
	logic [31:0] rnd;
	logic gie = 1'b0;
	logic tm, im;
	// 50 MHz system clock
	always #10 CORE_CLK_I = ~CORE_CLK_I;
	core_exec uut (.CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I), .PMEM_DATA_I(PMEM_DATA_I),
		.DMEM_RDATA_I(DMEM_RDATA_I), .TBL_PAGE_I(TBL_PAGE_I), .WDT_TICK_I(WDT_TICK_I),
		.PMEM_ADDR_O(PMEM_ADDR_O), .DMEM_WE_O(DMEM_WE_O), .DMEM_ADDR_O(DMEM_ADDR_O),
		.DMEM_WDATA_O(DMEM_WDATA_O), .ACC_O(ACC_O), .FLAGS_O(FLAGS_O), .TABLE_HIGH_BYTE_O(TABLE_HIGH_BYTE_O),
		.TABLE_POINTER_O(TABLE_POINTER_O), .GIE_O(GIE_O), .POWERDOWN_O(POWERDOWN_O), .WDT_O(WDT_O));
	core_mem_model mem (.clk_i(CORE_CLK_I), .paddr_i(PMEM_ADDR_O), .pdata_o(PMEM_DATA_I),
		.we_i(DMEM_WE_O), .daddr_i(DMEM_ADDR_O), .wdata_i(DMEM_WDATA_O), .rdata_o(DMEM_RDATA_I));
	// Sparse watchdog ticks keep the timer far from expiry
	always @(posedge CORE_CLK_I) begin
		#1;
		WDT_TICK_I = ($random(seed) & 7) == 0;
		TBL_PAGE_I = $random(seed);
	end
	task automatic summarize;
		if (fail_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Model one instruction, let the core run its cycles, then compare
	task automatic step(input int op, input logic t, input logic i, input logic [7:0] a);
		logic [7:0] m, r, b, ci, msk;
		logic [8:0] s;
		logic [12:0] npc;
		logic [15:0] w;
		logic skip;
		int cyc;
		mem.pmem[pc] = {op[5:0], t, i, a};
		m = em[a];
		b = i ? a : m;
		ci = (op == 2 || op == 4) ? {7'h00, flg[FLAG_C]} : {7'h00, op == 3};
		cyc = 1;
		npc = pc + 13'h0001;
		msk = 8'hff;
		skip = 1'b0;
		r = 8'h00;
		case (op)
			1, 2: begin
				s = acc + b + ci;
				r = s[7:0];
				flg[FLAG_C] = s[8];
				flg[FLAG_HC] = ({1'b0, acc[3:0]} + b[3:0] + ci[3:0]) > 5'h0f;
				flg[FLAG_OV] = (acc[7] == b[7]) && (r[7] != acc[7]);
				msk = 8'hcf;
			end
			3, 4: begin
				// Carry set means no borrow; borrow-in is the inverse of carry
				s = {1'b0, acc} + {1'b0, ~b} + {1'b0, ci};
				r = s[7:0];
				flg[FLAG_C] = s[8];
				flg[FLAG_HC] = ({1'b0, acc[3:0]} + {1'b0, ~b[3:0]} + {1'b0, ci[3:0]}) > 5'h0f;
				flg[FLAG_OV] = (acc[7] != b[7]) && (r[7] != acc[7]);
				msk = 8'hcf;
			end
			5: begin
				s = {1'b0, acc};
				if (acc[3:0] > 4'h9 || flg[FLAG_HC]) s = s + 9'h006;
				if (s > 9'h09f || flg[FLAG_C]) begin
					s = s + 9'h060;
					flg[FLAG_C] = 1'b1;
				end
				em[a] = s[7:0];
			end
			6: r = acc & b;
			7: r = acc | b;
			8: r = acc ^ b;
			9: r = ~m;
			10: r = m + 8'h01;
			11: r = m - 8'h01;
			12: r = {m[0], m[7:1]};
			13: r = {m[6:0], m[7]};
			14: begin
				r = {flg[FLAG_C], m[7:1]};
				flg[FLAG_C] = m[0];
			end
			15: begin
				r = {m[6:0], flg[FLAG_C]};
				flg[FLAG_C] = m[7];
			end
			16: acc = m;
			17: if (a == PCL_ADDR) begin
				npc = {pc[12:8], acc};
				cyc = 2;
			end else em[a] = acc;
			18: acc = a;
			21: begin
				npc = {5'h00, a};
				cyc = 2;
			end
			22: begin
				stk.push_back(pc + 13'h0001);
				npc = {5'h00, a};
				cyc = 2;
			end
			23, 24, 25: begin
				npc = stk.pop_back();
				cyc = 2;
				if (op == 24) acc = a;
				if (op == 25) gie = 1'b1;
			end
			26: skip = m == 8'h00;
			27: skip = m != 8'h00;
			28: begin
				acc = m;
				skip = m == 8'h00;
			end
			31: begin
				r = m + 8'h01;
				skip = r == 8'h00;
			end
			34: begin
				if (t) table_pointer = table_pointer + 8'h01;
				w = mem.pmem[{5'h1f, table_pointer}];
				table_high_byte = w[15:8];
				em[a] = w[7:0];
				cyc = 2;
			end
			35: em[a] = 8'h00;
			36: em[a] = 8'hff;
			37: r = {m[3:0], m[7:4]};
			default: ;
		endcase
		if (op inside {[1:4], [6:11]}) flg[FLAG_Z] = r == 8'h00;
		if (op inside {[1:4], [6:15], 31, 37}) begin
			if (t) em[a] = r;
			else acc = r;
		end
		if (skip) begin
			npc = pc + 13'h0002;
			cyc = 2;
		end
		pc = npc;
		repeat (4 * (cyc + 1)) @(posedge CORE_CLK_I);
		#2;
		`CHK("acc", ACC_O, acc)
		`CHK("flags", FLAGS_O & msk, flg & msk)
		`CHK("pc", PMEM_ADDR_O, pc)
		`CHK("gie", GIE_O, gie)
		`CHK("table_high_byte", TABLE_HIGH_BYTE_O, table_high_byte)
		`CHK("table_pointer", TABLE_POINTER_O, table_pointer)
		`CHK("pdn", POWERDOWN_O, 1'b0)
		if (a != PCL_ADDR) `CHK("mem", mem.dmem[a], em[a])
		flg = (flg & msk) | (FLAGS_O & ~msk);
	endtask
	// Watchdog on a hang, well past the expected run length
	initial begin
		#400000;
		fail_count++;
		summarize();
	end
	initial begin
		for (int k = 0; k < 256; k++) begin
			em[k] = $random(seed);
			mem.dmem[k] = em[k];
			mem.pmem[{5'h1f, k[7:0]}] = $random(seed);
		end
		repeat (16) @(posedge CORE_CLK_I);
		#1;
		RESET_I = 1'b0;
		step(22, 1'b0, 1'b0, 8'h20);
		step(24, 1'b0, 1'b0, 8'h5a);
		step(22, 1'b0, 1'b0, 8'h30);
		step(25, 1'b0, 1'b0, 8'h00);
		step(22, 1'b0, 1'b0, 8'h40);
		step(23, 1'b0, 1'b0, 8'h00);
		step(21, 1'b0, 1'b0, 8'h80);
		step(17, 1'b0, 1'b0, PCL_ADDR);
		// Random operands over the operations in opl; of the skips only SZ, SNZ, SZA and SIZ
		for (int k = 0; k < 8; k++) begin
			foreach (opl[j]) begin
				rnd = $random(seed);
				tm = (rnd[0] && opl[j] inside {[1:4], [6:15], 31, 34, 37}) || opl[j] == 5;
				im = !tm && rnd[1] && opl[j] inside {1, 3, 4, 6, 7, 8};
				v = im ? rnd[15:8] : {2'b01, rnd[13:8]};
				if (opl[j] >= 26 && rnd[2]) begin
					em[v] = (opl[j] == 31) ? 8'hff : 8'h00;
					mem.dmem[v] = em[v];
				end
				step(opl[j], tm, im, v);
			end
		end
		// Bit number sits in the low three operand bits; the count and the place of the changed bit are checked
		for (int k = 0; k < 8; k++) begin
			rnd = $random(seed);
			v = {2'b01, rnd[5:0]};
			mem.pmem[pc] = {6'(19 + k % 2), 2'b00, v};
			pc = pc + 13'h0001;
			repeat (8) @(posedge CORE_CLK_I);
			#2;
			`CHK("bit_count", $countones(mem.dmem[v] ^ em[v]) <= 1, 1'b1)
			`CHK("bit_mem", mem.dmem[v], (k % 2) ? (em[v] | (8'h01 << v[2:0])) : (em[v] & ~(8'h01 << v[2:0])))
			`CHK("bit_flags", FLAGS_O, flg)
			`CHK("bit_pc", PMEM_ADDR_O, pc)
			em[v] = mem.dmem[v];
		end
		summarize();
	end
endmodule
`default_nettype wire
